// ===== pps_defines.svh
// Register indices, field positions and reset values of the pin modulation selector.
// Assumes byte address = index * 4 on a 32-bit AXI4-Lite bus.
`ifndef PPS_DEFINES_SVH
`define PPS_DEFINES_SVH
// ----------------------------------------
// Register indices
// ----------------------------------------
`define PPS_IDX_CHSEL 5'h00
`define PPS_IDX_FR1 5'h01
`define PPS_IDX_CFR 5'h03
`define PPS_IDX_FTW0 5'h04
`define PPS_IDX_POW 5'h05
`define PPS_IDX_ACW 5'h06
`define PPS_IDX_CW_BASE 5'h09
`define PPS_IDX_CW1 5'h0A
`define PPS_IDX_CW15 5'h18
`define PPS_IDX_STAT 5'h1F
// ----------------------------------------
// Field positions
// ----------------------------------------
`define PPS_FR1_LVL_LSB 8
`define PPS_FR1_RAMP_LSB 10
`define PPS_FR1_PCFG_LSB 12
`define PPS_CFR_SWEEP_BIT 14
`define PPS_CFR_TYPE_LSB 22
`define PPS_PHASE_LSB 18
`define PPS_AMP_LSB 22
// ----------------------------------------
// Reset values and answers
// ----------------------------------------
`define PPS_CHSEL_RESET 2'h3
`define PPS_WORD_RESET 32'h0000_0000
`define PPS_PCFG_101 3'h5
`define PPS_RESP_OKAY 2'h0
`define PPS_RESP_SLVERR 2'h2
`endif

// ===== pps_pkg.sv
// Types shared by the pin modulation selector.
// Numbers are written in place; pps_defines.svh is not used.
package pps_pkg;
  // Modulated quantity per channel
  typedef enum logic [1:0] {
    PPS_MT_OFF = 2'h0,
    PPS_MT_AMP = 2'h1,
    PPS_MT_FREQ = 2'h2,
    PPS_MT_PHASE = 2'h3
  } pps_mtype_t;
  // Function register one fields
  typedef struct packed {
    logic [2:0] pin_cfg;
    logic [1:0] ramp_src;
    logic [1:0] level;
  } pps_fr1_t;
  // Channel function register fields
  typedef struct packed {
    pps_mtype_t mtype;
    logic sweep;
  } pps_cfr_t;
  // Pin levels carried through the synchronisers
  typedef struct packed {
    logic [2:0] sdio;
    logic [3:0] sel;
  } pps_pins_t;
  // Per-channel result
  typedef struct packed {
    logic [3:0] word_index;
    logic [31:0] freq_word;
    logic [13:0] phase_word;
    logic [9:0] amp_word;
    logic ramp_active;
    logic ramp_down;
  } pps_chan_out_t;
endpackage

// ===== pps_top.sv
// Profile pin modulation selector with AXI4-Lite register access.
// Assumes pins and serial data lines are asynchronous to aclk.
// Summary of operation
// - Ramp pin low asks ramp-up, high asks ramp-down.
// - Pin configuration field assigns pins to channels.
// - Two-level no ramp: P2 drives channel zero, P3 channel one.
// - Two-level frequency: P2 low picks word 0, high picks word 1.
// - Four-level, config 101: P0,P1 index channel zero; P2,P3 channel one.
// - First pin of each pair is the index MSB.
// - Eight-level: P0..P2 go to channel per X10/X11; P3 ignored.
// - Eight-level index is P0 (MSB) to P2.
// - Sixteen-level: all pins go to channel per X10/X11.
// - Sixteen-level index is P0 (MSB) to P3.
// - No-ramp modes need ramp source and sweep cleared.
// - Ramp source 01: two-level, config 101 only, P0/P1 index, P2/P3 ramp.
// - Ramp source 10: eight-level only, P3 ramps chosen channel.
// - Ramp source 11: ramp from serial lines, levels 2/4/16.
// - Serial port single-bit while serial lines carry ramp.
// - Type 00 off, 01 amplitude, 10 frequency, 11 phase.
// - Words 1..15 at 0x0A..0x18; word 0 is dedicated.
// - Phase and amplitude taken from word MSBs.
//
// The address map and the AXI4-Lite register port were decided locally.
`include "pps_defines.svh"
`timescale 1ns/1ps
module pps_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [6:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [6:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] select_pin,
  input wire logic [2:0] serial_ramp_pin,
  output pps_pkg::pps_chan_out_t channel_zero_out,
  output pps_pkg::pps_chan_out_t channel_one_out
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  pps_pkg::pps_pins_t sync1_q, sync1_d;
  pps_pkg::pps_pins_t sync2_q, sync2_d;
  pps_pkg::pps_fr1_t fr1_q, fr1_d;
  pps_pkg::pps_cfr_t cfr_q [2];
  pps_pkg::pps_cfr_t cfr_d [2];
  logic [1:0] chsel_q, chsel_d;
  logic [31:0] cw_q [2][16];
  logic [31:0] cw_d [2][16];
  logic [13:0] pow_q [2];
  logic [13:0] pow_d [2];
  logic [9:0] acw_q [2];
  logic [9:0] acw_d [2];
  logic [3:0] idx_q [2];
  logic [3:0] idx_d [2];
  logic [1:0] ron_q, ron_d;
  logic [1:0] rdn_q, rdn_d;
  pps_pkg::pps_chan_out_t out_q [2];
  pps_pkg::pps_chan_out_t out_d [2];
  logic aw_got_q, aw_got_d;
  logic [4:0] aw_idx_q, aw_idx_d;
  logic w_got_q, w_got_d;
  logic [31:0] w_data_q, w_data_d;
  logic [3:0] w_strb_q, w_strb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic aw_take, w_take, do_wr;
  logic [4:0] wr_idx;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;

  // ----------------------------------------
  // Register helpers
  // ----------------------------------------
  // Index is a known register
  function automatic logic mapped(input logic [4:0] idx);
    mapped = (idx == `PPS_IDX_CHSEL) || (idx == `PPS_IDX_FR1) ||
             (idx == `PPS_IDX_CFR) || (idx == `PPS_IDX_STAT) ||
             (idx >= `PPS_IDX_FTW0 && idx <= `PPS_IDX_ACW) ||
             (idx >= `PPS_IDX_CW1 && idx <= `PPS_IDX_CW15);
  endfunction

  // Readback of one register for one channel
  function automatic logic [31:0] rd_word(input logic [4:0] idx, input logic ch);
    logic [31:0] v;
    v = `PPS_WORD_RESET;
    if (idx == `PPS_IDX_CHSEL) begin
      v = 32'(chsel_q);
    end else if (idx == `PPS_IDX_FR1) begin
      v = (32'(fr1_q.level) << `PPS_FR1_LVL_LSB) |
          (32'(fr1_q.ramp_src) << `PPS_FR1_RAMP_LSB) |
          (32'(fr1_q.pin_cfg) << `PPS_FR1_PCFG_LSB);
    end else if (idx == `PPS_IDX_CFR) begin
      v = (32'(cfr_q[ch].mtype) << `PPS_CFR_TYPE_LSB) |
          (32'(cfr_q[ch].sweep) << `PPS_CFR_SWEEP_BIT);
    end else if (idx == `PPS_IDX_FTW0) begin
      v = cw_q[ch][0];
    end else if (idx == `PPS_IDX_POW) begin
      v = 32'(pow_q[ch]);
    end else if (idx == `PPS_IDX_ACW) begin
      v = 32'(acw_q[ch]);
    end else if (idx >= `PPS_IDX_CW1 && idx <= `PPS_IDX_CW15) begin
      v = cw_q[ch][4'(idx - `PPS_IDX_CW_BASE)];
    end else if (idx == `PPS_IDX_STAT) begin
      v = {20'h0_0000, rdn_q, ron_q, idx_q[1], idx_q[0]};
    end
    rd_word = v;
  endfunction

  // Byte-lane merge of write data
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] v;
    v = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        v[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    merge = v;
  endfunction

  // ----------------------------------------
  // AXI4-Lite handshakes
  // ----------------------------------------
  assign s_axi_awready = !aw_got_q && !bvalid_q;
  assign s_axi_wready = !w_got_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign do_wr = (aw_got_q || aw_take) && (w_got_q || w_take);
  assign wr_idx = aw_got_q ? aw_idx_q : s_axi_awaddr[6:2];
  assign wr_data = w_got_q ? w_data_q : s_axi_wdata;
  assign wr_strb = w_got_q ? w_strb_q : s_axi_wstrb;

  // Write and read channel next state
  always_comb begin
    aw_got_d = aw_got_q;
    aw_idx_d = aw_idx_q;
    w_got_d = w_got_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (do_wr) begin
      aw_got_d = 1'b0;
      w_got_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = mapped(wr_idx) ? `PPS_RESP_OKAY : `PPS_RESP_SLVERR;
    end else begin
      if (aw_take) begin
        aw_got_d = 1'b1;
        aw_idx_d = s_axi_awaddr[6:2];
      end
      if (w_take) begin
        w_got_d = 1'b1;
        w_data_d = s_axi_wdata;
        w_strb_d = s_axi_wstrb;
      end
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rdata_d = rd_word(s_axi_araddr[6:2], !chsel_q[0]);
      rresp_d = mapped(s_axi_araddr[6:2]) ? `PPS_RESP_OKAY : `PPS_RESP_SLVERR;
    end
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  // Store writes; per-channel registers go to every selected channel
  always_comb begin
    logic [31:0] v;
    v = `PPS_WORD_RESET;
    fr1_d = fr1_q;
    chsel_d = chsel_q;
    cfr_d = cfr_q;
    cw_d = cw_q;
    pow_d = pow_q;
    acw_d = acw_q;
    if (do_wr) begin
      v = merge(rd_word(wr_idx, 1'b0), wr_data, wr_strb);
      if (wr_idx == `PPS_IDX_CHSEL) begin
        chsel_d = v[1:0];
      end
      if (wr_idx == `PPS_IDX_FR1) begin
        fr1_d.level = v[`PPS_FR1_LVL_LSB +: 2];
        fr1_d.ramp_src = v[`PPS_FR1_RAMP_LSB +: 2];
        fr1_d.pin_cfg = v[`PPS_FR1_PCFG_LSB +: 3];
      end
      for (int c = 0; c < 2; c++) begin
        v = merge(rd_word(wr_idx, c[0]), wr_data, wr_strb);
        if (chsel_q[c]) begin
          if (wr_idx == `PPS_IDX_CFR) begin
            cfr_d[c].mtype = pps_pkg::pps_mtype_t'(v[`PPS_CFR_TYPE_LSB +: 2]);
            cfr_d[c].sweep = v[`PPS_CFR_SWEEP_BIT];
          end
          if (wr_idx == `PPS_IDX_FTW0) begin
            cw_d[c][0] = v;
          end
          if (wr_idx == `PPS_IDX_POW) begin
            pow_d[c] = v[13:0];
          end
          if (wr_idx == `PPS_IDX_ACW) begin
            acw_d[c] = v[9:0];
          end
          if (wr_idx >= `PPS_IDX_CW1 && wr_idx <= `PPS_IDX_CW15) begin
            cw_d[c][4'(wr_idx - `PPS_IDX_CW_BASE)] = v;
          end
        end
      end
    end
  end

  // ----------------------------------------
  // Pin decode
  // ----------------------------------------
  // Two-flop synchronisers for all pins together
  always_comb begin
    sync1_d.sel = select_pin;
    sync1_d.sdio = serial_ramp_pin;
    sync2_d = sync1_q;
  end

  // Pins to channel word index and ramp control
  always_comb begin
    logic [3:0] p;
    logic [2:0] s;
    logic ch;
    logic ok;
    logic quad;
    p = sync2_q.sel;
    s = sync2_q.sdio;
    ch = fr1_q.pin_cfg[0];
    ok = fr1_q.pin_cfg[1];
    quad = (fr1_q.pin_cfg == `PPS_PCFG_101);
    idx_d[0] = 4'h0;
    idx_d[1] = 4'h0;
    ron_d = 2'h0;
    rdn_d = 2'h0;
    case (fr1_q.ramp_src)
      2'h0, 2'h3: begin
        case (fr1_q.level)
          2'h0: begin
            idx_d[0] = {3'h0, p[2]};
            idx_d[1] = {3'h0, p[3]};
          end
          2'h1: begin
            if (quad) begin
              idx_d[0] = {2'h0, p[0], p[1]};
              idx_d[1] = {2'h0, p[2], p[3]};
            end
          end
          2'h2: begin
            if (ok && fr1_q.ramp_src == 2'h0) begin
              idx_d[ch] = {1'h0, p[0], p[1], p[2]};
            end
          end
          default: begin
            if (ok) begin
              idx_d[ch] = {p[0], p[1], p[2], p[3]};
            end
          end
        endcase
        if (fr1_q.ramp_src == 2'h3) begin
          case (fr1_q.level)
            2'h0: begin
              if (s[0]) begin
                ron_d[s[1]] = 1'b1;
                rdn_d[s[1]] = s[2];
              end
            end
            2'h1: begin
              if (quad) begin
                ron_d = 2'h3;
                rdn_d = {s[1], s[0]};
              end
            end
            2'h3: begin
              if (ok) begin
                ron_d[ch] = 1'b1;
                rdn_d[ch] = s[0];
              end
            end
            default: begin
              idx_d[0] = 4'h0;
            end
          endcase
        end
      end
      2'h1: begin
        if (fr1_q.level == 2'h0 && quad) begin
          idx_d[0] = {3'h0, p[0]};
          idx_d[1] = {3'h0, p[1]};
          ron_d = 2'h3;
          rdn_d = {p[3], p[2]};
        end
      end
      default: begin
        if (fr1_q.level == 2'h2 && ok) begin
          idx_d[ch] = {1'h0, p[0], p[1], p[2]};
          ron_d[ch] = 1'b1;
          rdn_d[ch] = p[3];
        end
      end
    endcase
    // Disabled type or sweep holds word 0
    for (int c = 0; c < 2; c++) begin
      if (cfr_q[c].mtype == pps_pkg::PPS_MT_OFF || cfr_q[c].sweep) begin
        idx_d[c] = 4'h0;
      end
    end
  end

  // ----------------------------------------
  // Per-channel word selection
  // ----------------------------------------
  for (genvar g = 0; g < 2; g++) begin : g_chan
    // Modulated quantity from the indexed word
    always_comb begin
      logic [31:0] w;
      logic hit;
      w = cw_q[g][idx_q[g]];
      hit = (idx_q[g] != 4'h0);
      out_d[g].word_index = idx_q[g];
      out_d[g].ramp_active = ron_q[g];
      out_d[g].ramp_down = rdn_q[g];
      out_d[g].freq_word = cw_q[g][0];
      out_d[g].phase_word = pow_q[g];
      out_d[g].amp_word = acw_q[g];
      case (cfr_q[g].mtype)
        pps_pkg::PPS_MT_FREQ: out_d[g].freq_word = w;
        pps_pkg::PPS_MT_PHASE: begin
          if (hit) begin
            out_d[g].phase_word = w[`PPS_PHASE_LSB +: 14];
          end
        end
        pps_pkg::PPS_MT_AMP: begin
          if (hit) begin
            out_d[g].amp_word = w[`PPS_AMP_LSB +: 10];
          end
        end
        default: out_d[g].word_index = 4'h0;
      endcase
    end
  end

  assign channel_zero_out = out_q[0];
  assign channel_one_out = out_q[1];

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // All state with synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
      fr1_q <= '0;
      chsel_q <= `PPS_CHSEL_RESET;
      ron_q <= 2'h0;
      rdn_q <= 2'h0;
      aw_got_q <= 1'b0;
      aw_idx_q <= 5'h00;
      w_got_q <= 1'b0;
      w_data_q <= `PPS_WORD_RESET;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `PPS_RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= `PPS_WORD_RESET;
      rresp_q <= `PPS_RESP_OKAY;
      for (int c = 0; c < 2; c++) begin
        cfr_q[c] <= '0;
        pow_q[c] <= 14'h0000;
        acw_q[c] <= 10'h000;
        idx_q[c] <= 4'h0;
        out_q[c] <= '0;
        for (int k = 0; k < 16; k++) begin
          cw_q[c][k] <= `PPS_WORD_RESET;
        end
      end
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      fr1_q <= fr1_d;
      chsel_q <= chsel_d;
      cfr_q <= cfr_d;
      cw_q <= cw_d;
      pow_q <= pow_d;
      acw_q <= acw_d;
      idx_q <= idx_d;
      ron_q <= ron_d;
      rdn_q <= rdn_d;
      out_q <= out_d;
      aw_got_q <= aw_got_d;
      aw_idx_q <= aw_idx_d;
      w_got_q <= w_got_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end
endmodule // pps_top

// ===== pps_chk.sv
// Port checker for the pin modulation selector.
// Assumes full-strobe writes, with address and data offered together.
`include "pps_defines.svh"
`timescale 1ns/1ps
module pps_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [6:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] select_pin,
  input wire logic [2:0] serial_ramp_pin,
  input wire pps_pkg::pps_chan_out_t channel_zero_out,
  input wire pps_pkg::pps_chan_out_t channel_one_out
);
  // ----------------------------------------
  // Helpers and properties
  // ----------------------------------------
  logic [6:0] fr1_q, fr1_d, pins_q, pins_d;
  logic [2:0] stab_q, stab_d, age_q, age_d;
  logic wr_fire;
  // Mirror of the function register, settle counters
  always_comb begin
    wr_fire = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    fr1_d = (wr_fire && s_axi_awaddr == {`PPS_IDX_FR1, 2'h0}) ? s_axi_wdata[14:8] : fr1_q;
    age_d = wr_fire ? 3'h0 : age_q + {2'h0, age_q != 3'h7};
    pins_d = {select_pin, serial_ramp_pin};
    stab_d = (pins_d != pins_q) ? 3'h0 : stab_q + {2'h0, stab_q != 3'h7};
  end
  // Register the helpers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fr1_q <= 7'h00;
      age_q <= 3'h0;
      stab_q <= 3'h0;
      pins_q <= 7'h00;
    end else begin
      fr1_q <= fr1_d;
      age_q <= age_d;
      stab_q <= stab_d;
      pins_q <= pins_d;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_settled;
    stab_q >= 3'h5 && age_q >= 3'h4;
  endsequence
  property p_wr_answer; s_wr_taken |=> s_axi_bvalid; endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_b_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_b_block: assert property (p_b_block) else $error("write taken during response");
  property p_rd_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_r_done; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_r_done: assert property (p_r_done) else $error("read answer repeated");
  property p_no_ramp;
    s_settled ##0 (fr1_q[3:2] == 2'h0) |-> !channel_zero_out.ramp_active && !channel_one_out.ramp_active;
  endproperty
  a_no_ramp: assert property (p_no_ramp) else $error("ramp active with ramp off");
  property p_pin_ramp;
    s_settled ##0 (fr1_q == 7'h54) |-> channel_zero_out.ramp_down == select_pin[2]
      && channel_one_out.ramp_down == select_pin[3];
  endproperty
  a_pin_ramp: assert property (p_pin_ramp) else $error("pin ramp direction wrong");
  property p_sdio_ramp;
    s_settled ##0 (fr1_q == 7'h5D) |-> channel_zero_out.ramp_down == serial_ramp_pin[0]
      && channel_one_out.ramp_down == serial_ramp_pin[1];
  endproperty
  a_sdio_ramp: assert property (p_sdio_ramp) else $error("serial ramp direction wrong");
endmodule // pps_chk
bind pps_top pps_chk u_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .select_pin, .serial_ramp_pin, .channel_zero_out, .channel_one_out);

// ===== pps_ctrl_model.sv
// Model of the controller that drives the profile and serial ramp pins.
// Assumes the bench supplies the wanted pin levels.
`timescale 1ns/1ps
module pps_ctrl_model (
  input wire logic aclk,
  input wire logic [3:0] req_pins,
  input wire logic [2:0] req_sdio,
  output logic [3:0] select_pin,
  output logic [2:0] serial_ramp_pin
);
  // Levels change just after an edge, then hold
  always_ff @(posedge aclk) begin
    select_pin <= req_pins;
    serial_ramp_pin <= req_sdio;
  end
endmodule // pps_ctrl_model

// ===== profile_pin_modulation_select_test.sv
// Bench for the pin modulation selector: AXI4-Lite tasks and mode table.
// Assumes pps_top, pps_chk and pps_ctrl_model are compiled alongside.
`include "pps_defines.svh"
`timescale 1ns/1ps
module profile_pin_modulation_select_test;
  // ----------------------------------------
  // Signals, tasks and sequence
  // ----------------------------------------
  logic aclk, aresetn;
  logic [6:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot, serial_ramp_pin, req_sdio;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, select_pin, req_pins;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  pps_pkg::pps_chan_out_t channel_zero_out, channel_one_out;
  int n_errors, samples_checked;
  pps_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .select_pin, .serial_ramp_pin, .channel_zero_out, .channel_one_out);
  pps_ctrl_model u_ctrl (.aclk, .req_pins, .req_sdio, .select_pin, .serial_ramp_pin);
  // Clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic results();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tmo();
    cmp(32'h0000_0000, 32'h0000_0001);
    results();
  endtask
  function automatic logic [31:0] cwv(input logic [3:0] i);
    return 32'h1357_9BDF * (32'(i) + 32'h0000_0001);
  endfunction
  task automatic wr(input logic [4:0] idx, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic aw_t, w_t;
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      aw_t = s_axi_awvalid & s_axi_awready;
      w_t = s_axi_wvalid & s_axi_wready;
      if (s_axi_bvalid === 1'b1) break;
      @(posedge aclk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
    end
    if (n == 50) tmo();
    cmp(32'(s_axi_bresp), 32'(er));
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdc(input logic [4:0] idx, input logic [31:0] ed, input logic [1:0] er);
    int n;
    logic ar_t;
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      ar_t = s_axi_arvalid & s_axi_arready;
      if (s_axi_rvalid === 1'b1) break;
      @(posedge aclk);
      if (ar_t) s_axi_arvalid <= 1'b0;
    end
    if (n == 50) tmo();
    cmp(s_axi_rdata, ed);
    cmp(32'(s_axi_rresp), 32'(er));
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask
  task automatic chk(input pps_pkg::pps_chan_out_t c, input logic [1:0] t, input logic [3:0] e);
    logic [31:0] w;
    w = cwv(e);
    cmp(32'(c.word_index), 32'(e));
    case (t)
      2'h2: cmp(c.freq_word, w);
      2'h3: cmp(32'(c.phase_word), 32'((e == 4'h0) ? 14'h2A5C : w[31:18]));
      2'h1: cmp(32'(c.amp_word), 32'((e == 4'h0) ? 10'h1C3 : w[31:22]));
      default: ;
    endcase
  endtask
  task automatic mc(input logic [2:0] pc, input logic [1:0] sr, input logic [1:0] lv, input logic [3:0] pn,
    input logic [2:0] sd, input logic [1:0] t0, input logic [1:0] t1, input logic [3:0] e0,
    input logic [3:0] e1, input logic [1:0] ra, input logic [1:0] rn);
    wr(`PPS_IDX_CHSEL, 32'h0000_0001, `PPS_RESP_OKAY);
    wr(`PPS_IDX_CFR, {8'h00, t0, 22'h00_0000}, `PPS_RESP_OKAY);
    wr(`PPS_IDX_CHSEL, 32'h0000_0002, `PPS_RESP_OKAY);
    wr(`PPS_IDX_CFR, {8'h00, t1, 22'h00_0000}, `PPS_RESP_OKAY);
    wr(`PPS_IDX_FR1, {17'h0_0000, pc, sr, lv, 8'h00}, `PPS_RESP_OKAY);
    req_pins <= pn;
    req_sdio <= sd;
    repeat (8) @(posedge aclk);
    @(negedge aclk);
    chk(channel_zero_out, t0, e0);
    chk(channel_one_out, t1, e1);
    cmp(32'({channel_one_out.ramp_active, channel_zero_out.ramp_active}), 32'(ra));
    cmp(32'({channel_one_out.ramp_down, channel_zero_out.ramp_down}), 32'(rn));
    rdc(`PPS_IDX_STAT, {20'h0_0000, rn, ra, e1, e0}, `PPS_RESP_OKAY);
  endtask
  // Main sequence
  initial begin
    int i;
    n_errors = 0;
    samples_checked = 0;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awprot, s_axi_arprot, req_pins, req_sdio} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(`PPS_IDX_CHSEL, 32'h0000_0003, `PPS_RESP_OKAY);
    rdc(`PPS_IDX_FR1, 32'h0000_0000, `PPS_RESP_OKAY);
    rdc(`PPS_IDX_CW15, 32'h0000_0000, `PPS_RESP_OKAY);
    wr(5'h02, 32'hFFFF_FFFF, `PPS_RESP_SLVERR);
    rdc(5'h02, 32'h0000_0000, `PPS_RESP_SLVERR);
    wr(`PPS_IDX_STAT, 32'hFFFF_FFFF, `PPS_RESP_OKAY);
    rdc(`PPS_IDX_STAT, 32'h0000_0000, `PPS_RESP_OKAY);
    wr(`PPS_IDX_CHSEL, 32'hFFFF_FFFF, `PPS_RESP_OKAY);
    rdc(`PPS_IDX_CHSEL, 32'h0000_0003, `PPS_RESP_OKAY);
    $display("test regs done");
    wr(`PPS_IDX_FTW0, cwv(4'h0), `PPS_RESP_OKAY);
    wr(`PPS_IDX_POW, 32'h0000_2A5C, `PPS_RESP_OKAY);
    wr(`PPS_IDX_ACW, 32'h0000_01C3, `PPS_RESP_OKAY);
    for (i = 1; i < 16; i++) wr(5'(`PPS_IDX_CW_BASE + i), cwv(4'(i)), `PPS_RESP_OKAY);
    rdc(`PPS_IDX_CW15, cwv(4'hF), `PPS_RESP_OKAY);
    mc(3'h0, 2'h0, 2'h0, 4'h4, 3'h0, 2'h2, 2'h2, 4'h1, 4'h0, 2'h0, 2'h0);
    mc(3'h7, 2'h0, 2'h0, 4'h8, 3'h0, 2'h3, 2'h1, 4'h0, 4'h1, 2'h0, 2'h0);
    mc(3'h5, 2'h0, 2'h1, 4'hB, 3'h0, 2'h2, 2'h2, 4'h3, 4'h1, 2'h0, 2'h0);
    mc(3'h5, 2'h0, 2'h1, 4'hB, 3'h0, 2'h0, 2'h2, 4'h0, 4'h1, 2'h0, 2'h0);
    mc(3'h2, 2'h0, 2'h2, 4'hF, 3'h0, 2'h2, 2'h0, 4'h7, 4'h0, 2'h0, 2'h0);
    mc(3'h3, 2'h0, 2'h3, 4'h7, 3'h0, 2'h0, 2'h2, 4'h0, 4'hE, 2'h0, 2'h0);
    mc(3'h5, 2'h1, 2'h0, 4'h9, 3'h0, 2'h2, 2'h2, 4'h1, 4'h0, 2'h3, 2'h2);
    mc(3'h6, 2'h2, 2'h2, 4'hD, 3'h0, 2'h3, 2'h0, 4'h5, 4'h0, 2'h1, 2'h1);
    mc(3'h5, 2'h3, 2'h1, 4'h6, 3'h2, 2'h1, 2'h2, 4'h1, 4'h2, 2'h3, 2'h2);
    mc(3'h0, 2'h3, 2'h0, 4'h4, 3'h7, 2'h2, 2'h2, 4'h1, 4'h0, 2'h2, 2'h2);
    mc(3'h3, 2'h3, 2'h3, 4'hB, 3'h1, 2'h0, 2'h2, 4'h0, 4'hD, 2'h2, 2'h2);
    $display("test modes done");
    results();
  end
endmodule // profile_pin_modulation_select_test
